// ==== common/sflh_pkg.sv ====
// Overview of operation
// R01 - fast read: opcode 0BH, 24-bit address MSB first, one dummy byte
// R02 - data bytes follow the eight dummy clocks, from the addressed byte
// R03 - device read address wraps from FFFFFH back to 000000H
// R04 - chip enable stays low for the whole read; its rise ends it
// R05 - byte program: 02H, 24-bit address, one data byte bit 7 first
// R06 - host programs only erased (FFH) locations
// R07 - program or erase starts only when chip enable rises after it
// R08 - write latch set command precedes every program or erase
// R09 - device ignores program or erase aimed at a protected area
// R10 - busy bit stays set during the operation; host polls or waits
// R11 - word program: ADH, address, two bytes, even address first
// R12 - after not-busy, ADH plus two bytes programs the next two
// R13 - inside word program only continuation, status read, clear valid
// R14 - end word program: wait not-busy, latch clear, check busy again
// R15 - word program never wraps; device exits at top address
// R16 - 70H before word program enables ready/busy on serial out
// R17 - with that enabled, low chip enable shows busy 0, ready 1
// R18 - 80H turns ready/busy signalling off again
// R19 - block erase: D8H plus address, bits 16 up pick 64K block
// R20 - sector erase: 20H plus address, bits 12 up pick 4K sector
// R21 - chip erase 60H or C7H, ignored if anything is protected
// R22 - status read served any time, repeated every eight clocks
// R23 - latch set command sets the write latch flag
// R24 - latch clear command clears the write latch flag
// R25 - device clears write latch flag when the operation completes
package sflh_pkg;

	// ---------------------------------------------------------------
	// flash opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_BYTE_PROG = 8'h02;
	localparam logic [7:0] OP_WORD_PROG = 8'hAD;
	localparam logic [7:0] OP_HW_BUSY_ON = 8'h70;
	localparam logic [7:0] OP_HW_BUSY_OFF = 8'h80;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE2 = 8'hC7;

	// ---------------------------------------------------------------
	// register map and fields
	// ---------------------------------------------------------------
	localparam logic [4:0] REG_CMD = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_TX = 5'h08;
	localparam logic [4:0] REG_RX = 5'h0C;
	localparam logic [4:0] REG_STAT = 5'h10;
	localparam int CMD_ADDR_BIT = 8;
	localparam int CMD_DUMMY_BIT = 9;
	localparam int CMD_READ_BIT = 10;
	localparam int CMD_LATCH_BIT = 11;
	localparam int CMD_WAIT_BIT = 12;
	localparam int CMD_HW_BIT = 13;
	localparam int CMD_NB_LSB = 16;
	localparam int SR_BUSY_BIT = 0;

	// ---------------------------------------------------------------
	// frame lengths in bits
	// ---------------------------------------------------------------
	localparam int FRAME_W = 72;
	localparam logic [6:0] LEN_OP = 7'h08;
	localparam logic [6:0] LEN_ADDR = 7'h18;
	localparam logic [6:0] LEN_DUMMY = 7'h08;
	localparam logic [6:0] LEN_POLL = 7'h10;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS = 8;
	localparam int CE_HIGH_NS = 50;
	localparam int CE_HIGH_CYC = (CE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int SENSE_NS = 40;
	localparam int SENSE_CYC = (SENSE_NS + CLK_NS - 1) / CLK_NS;

	// ---------------------------------------------------------------
	// state types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_LOAD = 3'b001,
		S_SHIFT = 3'b010,
		S_GAP = 3'b011,
		S_SENSE = 3'b100
	} sflh_state_e;

	typedef enum logic [1:0] {
		PH_PRE = 2'b00,
		PH_MAIN = 2'b01,
		PH_POLL = 2'b10,
		PH_SENSE = 2'b11
	} sflh_phase_e;

	typedef struct packed {
		sflh_state_e st;
		sflh_phase_e ph;
		logic [7:0] cnt;
		logic sck;
		logic cs_n;
		logic [FRAME_W-1:0] sh;
		logic [6:0] nbit;
		logic [31:0] rx;
		logic [23:0] addr;
		logic [31:0] tx;
		logic [31:0] cmd;
		logic [7:0] sr;
		logic ready;
		logic [31:0] rdata;
		logic rd_pend;
		logic so1;
		logic so2;
	} sflh_regs_s;

endpackage

// ==== core/sflh_ctrl.sv ====
`timescale 1ns/1ps
module sflh_ctrl import sflh_pkg::*; #(
	parameter int HALF_DIV = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// flash pins
	output logic sck,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);

	// ---------------------------------------------------------------
	// parameter check
	// ---------------------------------------------------------------
	if (HALF_DIV < 4 || HALF_DIV > 255) begin : g_bad_div
		$error("HALF_DIV must lie in 4..255");
	end

	localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);
	localparam logic [7:0] GAP_LAST = 8'(CE_HIGH_CYC - 1);
	localparam logic [7:0] SENSE_LAST = 8'(SENSE_CYC - 1);

	sflh_regs_s s, d;
	logic busy;
	logic rd_new;
	logic wait_wr;
	logic [FRAME_W-1:0] v;
	logic [6:0] n;

	// ---------------------------------------------------------------
	// bus handshake and pins
	// ---------------------------------------------------------------
	assign busy = (s.st != S_IDLE);
	assign rd_new = avs_read & ~s.rd_pend;
	assign wait_wr = avs_write & busy;
	assign avs_waitrequest = rd_new | wait_wr;
	assign avs_readdata = s.rdata;
	assign sck = s.sck;
	assign cs_n = s.cs_n;
	assign mosi = s.sh[FRAME_W-1];

	// next-state logic
	always_comb begin
		d = s;
		v = '0;
		n = '0;
		d.so1 = miso;
		d.so2 = s.so1;
		d.rd_pend = rd_new;
		// read data is loaded on the same edge that drops waitrequest
		if (rd_new) begin
			unique case (avs_address)
				REG_CMD: d.rdata = s.cmd;
				REG_ADDR: d.rdata = {8'h00, s.addr};
				REG_TX: d.rdata = s.tx;
				REG_RX: d.rdata = s.rx;
				REG_STAT: d.rdata = {16'h0000, s.sr, 6'h00, s.ready, busy};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
		// writes are stalled while a sequence runs
		if (avs_write && !busy) begin
			unique case (avs_address)
				REG_ADDR: d.addr = avs_writedata[23:0];
				REG_TX: d.tx = avs_writedata; // [R06] [R11]
				REG_CMD: begin
					d.cmd = avs_writedata;
					d.st = S_LOAD;
					// latch set frame goes first when asked for
					d.ph = avs_writedata[CMD_LATCH_BIT] ? PH_PRE : PH_MAIN; // [R08]
				end
				default: ;
			endcase
		end
		unique case (s.st)
			S_IDLE: begin
				d.cs_n = 1'b1;
				d.sck = 1'b0;
			end
			S_LOAD: begin
				// build the frame, left aligned, first bit out on top
				unique case (s.ph)
					PH_PRE: begin
						v = {OP_LATCH_SET, 64'h0}; // [R08]
						n = LEN_OP;
					end
					PH_POLL: begin
						v = {OP_STATUS_READ, 64'h0}; // [R10] [R22]
						n = LEN_POLL;
					end
					PH_MAIN: begin
						v = {s.cmd[7:0], 64'h0}; // [R01] [R05] [R16]
						n = LEN_OP;
						// continuation word program omits the address
						if (s.cmd[CMD_ADDR_BIT]) begin // [R12]
							v = v | ({s.addr, 48'h0} >> n); // [R19] [R20]
							n = n + LEN_ADDR;
						end
						if (s.cmd[CMD_DUMMY_BIT]) begin
							n = n + LEN_DUMMY; // [R02]
						end
						if (!s.cmd[CMD_READ_BIT]) begin
							v = v | ({s.tx, 40'h0} >> n); // [R05] [R11]
						end
						n = n + 7'({s.cmd[CMD_NB_LSB+:3], 3'b000});
						d.rx = 32'h0000_0000;
					end
					default: ;
				endcase
				d.sh = v;
				d.nbit = n;
				d.cnt = 8'h00;
				d.sck = 1'b0;
				d.cs_n = 1'b0;
				d.st = (s.ph == PH_SENSE) ? S_SENSE : S_SHIFT;
			end
			S_SHIFT: begin
				// chip enable held low until every bit has passed
				d.cs_n = 1'b0; // [R04]
				if (s.cnt == HALF_LAST) begin
					d.cnt = 8'h00;
					d.sck = ~s.sck;
					if (s.sck) begin
						// falling edge: take in, move next bit out
						d.rx = {s.rx[30:0], s.so2}; // [R02]
						d.sh = s.sh << 1;
						d.nbit = s.nbit - 7'h01;
						if (s.nbit == 7'h01) begin
							d.cs_n = 1'b1; // [R07]
							d.st = S_GAP;
						end
					end
				end else begin
					d.cnt = s.cnt + 8'h01;
				end
			end
			S_SENSE: begin
				// low chip enable shows ready/busy on serial out
				if (s.cnt == SENSE_LAST) begin
					d.ready = s.so2; // [R17]
					d.cs_n = 1'b1;
					d.cnt = 8'h00;
					d.st = S_GAP;
				end else begin
					d.cnt = s.cnt + 8'h01;
				end
			end
			S_GAP: begin
				d.cs_n = 1'b1;
				if (s.cnt == GAP_LAST) begin
					d.cnt = 8'h00;
					d.st = S_IDLE;
					unique case (s.ph)
						PH_PRE: begin
							d.ph = PH_MAIN;
							d.st = S_LOAD;
						end
						PH_MAIN: begin
							// optional wait for completion after launch
							if (s.cmd[CMD_WAIT_BIT]) begin // [R10] [R14]
								d.ph = s.cmd[CMD_HW_BIT] ? PH_SENSE : PH_POLL;
								d.st = S_LOAD;
							end
						end
						PH_POLL: begin
							d.sr = s.rx[7:0];
							if (s.rx[SR_BUSY_BIT]) begin // [R10]
								d.st = S_LOAD;
							end
						end
						PH_SENSE: begin
							if (!s.ready) begin // [R17]
								d.st = S_LOAD;
							end
						end
						default: ;
					endcase
				end else begin
					d.cnt = s.cnt + 8'h01;
				end
			end
			default: d.st = S_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.cs_n <= 1'b1;
			s.st <= S_IDLE;
			s.ph <= PH_MAIN;
		end else begin
			s <= d;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ce_high_min;
		cs_n[*7];
	endsequence

	property p_pre_opcode;
		$fell(cs_n) && s.ph == PH_PRE
			|-> s.sh[FRAME_W-1 -: 8] == OP_LATCH_SET;
	endproperty
	a_pre_opcode: assert property (p_pre_opcode) // [R08]
		else $error("latch set frame without its opcode");

	property p_ce_gap;
		$rose(cs_n) |-> s_ce_high_min;
	endproperty
	a_ce_gap: assert property (p_ce_gap) // [R07]
		else $error("chip enable high time too short");

	property p_ce_low_shift;
		s.st == S_SHIFT && s.nbit != 7'h00 |-> !cs_n;
	endproperty
	a_ce_low_shift: assert property (p_ce_low_shift) // [R04]
		else $error("chip enable rose inside a frame");

	property p_sck_idle;
		cs_n |-> !sck;
	endproperty
	a_sck_idle: assert property (p_sck_idle) // [R01]
		else $error("clock not low while deselected");

	property p_mosi_on_fall;
		!cs_n && $changed(mosi) && $past(!cs_n) |-> !sck && $past(sck);
	endproperty
	a_mosi_on_fall: assert property (p_mosi_on_fall) // [R05]
		else $error("serial data moved outside a falling edge");

	property p_poll_again;
		s.st == S_GAP && s.ph == PH_POLL && s.cnt == GAP_LAST
			&& s.rx[SR_BUSY_BIT] |=> s.st == S_LOAD ##1 $fell(cs_n);
	endproperty
	a_poll_again: assert property (p_poll_again) // [R10]
		else $error("busy status not polled again");

	property p_sense_low;
		$fell(cs_n) && s.ph == PH_SENSE |-> !cs_n[*2];
	endproperty
	a_sense_low: assert property (p_sense_low) // [R17]
		else $error("ready sense window too short");

	property p_write_stall;
		avs_write && busy |-> avs_waitrequest;
	endproperty
	a_write_stall: assert property (p_write_stall) // [R12]
		else $error("command taken while sequence runs");

	property p_frame_bits;
		$fell(cs_n) && s.ph == PH_POLL |-> s.nbit == LEN_POLL;
	endproperty
	a_frame_bits: assert property (p_frame_bits) // [R22]
		else $error("status poll frame of wrong length");

	// sense window: chip enable low for the sense count, then high
	sequence s_sense_hold;
		!cs_n[*5] ##1 cs_n;
	endsequence

	property p_main_opcode;
		$fell(cs_n) && s.ph == PH_MAIN
			|-> s.sh[FRAME_W-1 -: 8] == s.cmd[7:0];
	endproperty
	a_main_opcode: assert property (p_main_opcode) // [R01] [R05]
		else $error("main frame without its opcode");

	property p_sck_pace;
		$changed(sck)
			|-> $past(s.st) == S_SHIFT && $past(s.cnt) == HALF_LAST;
	endproperty
	a_sck_pace: assert property (p_sck_pace) // [R01]
		else $error("serial clock moved off its divider");

	property p_wait_follows;
		s.st == S_GAP && s.ph == PH_MAIN && s.cnt == GAP_LAST
			&& s.cmd[CMD_WAIT_BIT] |=> s.st == S_LOAD && s.ph != PH_MAIN;
	endproperty
	a_wait_follows: assert property (p_wait_follows) // [R10]
		else $error("no completion wait after launch");

	property p_sense_hold;
		$fell(cs_n) && s.ph == PH_SENSE |-> s_sense_hold;
	endproperty
	a_sense_hold: assert property (p_sense_hold) // [R17]
		else $error("ready sense window of wrong length");

	property p_stat_busy;
		rd_new && avs_address == REG_STAT
			|=> avs_readdata[SR_BUSY_BIT] == $past(busy);
	endproperty
	a_stat_busy: assert property (p_stat_busy) // [R10]
		else $error("status register busy bit stale");

endmodule

// ==== tb/sflh_flash_model.sv ====
`timescale 1ns/1ps
// behavioural flash device on the far side of the serial pins
module sflh_flash_model #(
	parameter int BUSY_NS = 3000
) (
	// serial pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] mem [0:1048575];
	logic [7:0] op, ob = 8'h00;
	logic [23:0] ad;
	logic [15:0] dw;
	logic [19:0] wa;
	logic wlf = 0, busy = 0, awp = 0, hw = 0;
	int n = 0;
	event go;
	// released line shows the inverse of the last bit
	assign miso = cs_n ? ~ob[7] : (hw && awp) ? ~busy : ob[7];
	initial foreach (mem[i]) mem[i] = 8'hFF;
	// bit capture on sck rise
	always @(negedge cs_n) n = 0;
	always @(posedge sck) if (!cs_n) begin
		if (n < 8) op = {op[6:0], mosi};
		else if (n < 32) ad = {ad[22:0], mosi};
		else dw = {dw[14:0], mosi};
		n++;
	end
	// output shifts on sck fall
	always @(negedge sck) if (!cs_n && n >= 8) begin
		if (n % 8 != 0) ob = ob << 1;
		else if (op == 8'h05) ob = {1'b0, awp, 4'h0, wlf, busy};
		else if (op == 8'h0B && n >= 40) begin
			ob = mem[ad[19:0]];
			ad = ad + 1;
		end
	end
	task automatic pg(input logic [19:0] a, input logic [7:0] d);
		mem[a] = mem[a] & d;
		busy = 1;
		-> go;
	endtask
	task automatic wd(input logic [15:0] d);
		pg(wa, d[15:8]);
		pg(wa + 20'h1, d[7:0]);
		wa = wa + 20'h2;
		if (wa == 20'h0) {wlf, awp} = 2'b00;
	endtask
	task automatic er(input logic [19:0] a, input int sz);
		for (int i = 0; i < sz; i++) mem[a + i] = 8'hFF;
		busy = 1;
		-> go;
	endtask
	// self-timed operation end
	always @(go) begin
		#BUSY_NS busy = 0;
		if (!awp) wlf = 0;
	end
	// a command runs when chip enable rises
	always @(posedge cs_n) begin
		if (n == 8 && op == 8'h04) {wlf, awp} = 2'b00;
		else if (n == 8 && !awp && op == 8'h06) wlf = 1;
		else if (n == 8 && !awp && op == 8'h70) hw = 1;
		else if (n == 8 && !awp && op == 8'h80) hw = 0;
		else if (wlf && !busy && (!awp || op == 8'hAD)) case (op)
			8'h02: if (n == 40) pg(ad[19:0], dw[7:0]);
			8'hAD: if (awp) begin
				if (n == 24) wd(ad[15:0]);
			end else if (n == 48) begin
				wa = {ad[19:1], 1'b0};
				awp = 1;
				wd(dw);
			end
			8'hD8: if (n == 32) er({ad[19:16], 16'h0000}, 65536);
			8'h20: if (n == 32) er({ad[19:12], 12'h000}, 4096);
			8'h60, 8'hC7: if (n == 8) er(20'h0_0000, 1048576);
			default: ;
		endcase
	end
endmodule

// ==== tb/sflh_ctrl_tb.sv ====
`timescale 1ns/1ps
module sflh_ctrl_tb import sflh_pkg::*;;
	logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
	logic [4:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, r;
	logic avs_waitrequest, sck, cs_n, mosi, miso;
	int bad_count = 0, n_tests = 0;
	localparam logic [31:0] A = 32'h0000_0100, R = 32'h0000_0400;
	localparam logic [31:0] W = 32'h0000_0800, T = 32'h0000_1000;
	localparam logic [31:0] H = 32'h0000_2000, N1 = 32'h0001_0000;
	localparam logic [31:0] FR = OP_FAST_READ | A | 32'h0000_0200 | R;
	localparam logic [7:0] EOP [4] = '{8'h20, 8'hD8, 8'h60, 8'hC7};
	always #4 clk = ~clk;
	sflh_ctrl dut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sck(sck), .cs_n(cs_n),
		.mosi(mosi), .miso(miso));
	sflh_flash_model fl (.sck(sck), .cs_n(cs_n), .mosi(mosi),
		.miso(miso));
	// ----------------
	// bus and checks
	// ----------------
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
	endtask
	task automatic run(input logic [31:0] c, a, x);
		bus(1, REG_ADDR, a);
		bus(1, REG_TX, x);
		bus(1, REG_CMD, c);
		do bus(0, REG_STAT, 0); while (r[SR_BUSY_BIT] !== 1'b0);
	endtask
	task automatic rx(input logic [31:0] c, a);
		run(c, a, 0);
		bus(0, REG_RX, 0);
	endtask
	task automatic pr(input logic [31:0] a, input logic [7:0] b);
		run(OP_BYTE_PROG | A | W | T | N1, a, {b, 24'h00_0000});
	endtask
	task automatic chk(input logic [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic t_basic;
		chk(cs_n, 1);
		bus(0, 5'h14, 0);
		chk(r, 0);
		run(OP_LATCH_SET | T, 0, 0);
		chk(r[15:8], 8'h02);
		rx(OP_STATUS_READ | R | N1 * 2, 0);
		chk(r[15:0], 16'h0202);
		run(OP_LATCH_CLEAR, 0, 0);
		rx(OP_STATUS_READ | R | N1, 0);
		chk(r[7:0], 0);
		$display("basic done");
	endtask
	task automatic t_prog;
		pr(32'h0000_1234, 8'h3C);
		rx(FR | N1, 32'h0000_1234);
		chk(r[7:0], 8'h3C);
		rx(OP_STATUS_READ | R | N1, 0);
		chk(r[7:0], 0);
		run(OP_BYTE_PROG | A | T | N1, 32'h0000_2000, 0);
		rx(FR | N1, 32'h0000_2000);
		chk(r[7:0], 8'hFF);
		pr(32'h000F_FFFF, 8'h5A);
		pr(0, 8'hA5);
		rx(FR | N1 * 2, 32'h000F_FFFF);
		chk(r[15:0], 16'h5AA5);
		$display("prog done");
	endtask
	task automatic t_word;
		run(OP_HW_BUSY_ON, 0, 0);
		run(OP_WORD_PROG | A | W | T | H | N1 * 2, 32'h0000_3000,
			32'h1122_0000);
		chk(r[1], 1);
		run(OP_BYTE_PROG | A | W | N1, 32'h0000_3010, 0);
		run(OP_WORD_PROG | T | H | N1 * 2, 0, 32'h3344_0000);
		chk(r[1], 1);
		run(OP_LATCH_CLEAR | T, 0, 0);
		chk(r[15:8], 8'h00);
		run(OP_HW_BUSY_OFF, 0, 0);
		rx(FR | N1 * 4, 32'h0000_3000);
		chk(r, 32'h1122_3344);
		rx(FR | N1, 32'h0000_3010);
		chk(r[7:0], 8'hFF);
		$display("word done");
	endtask
	task automatic t_erase;
		for (int i = 0; i < 4; i++) begin
			pr(32'h0001_1234, 8'h00);
			run(EOP[i] | (i < 2 ? A : 0) | W | T, 32'h0001_1FFF, 0);
			rx(FR | N1, 32'h0001_1234);
			chk(r[7:0], 8'hFF);
			rx(FR | N1, 0);
			chk(r[7:0], i < 2 ? 8'hA5 : 8'hFF);
		end
		$display("erase done");
	endtask
	// ----------------
	// sequence
	// ----------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		t_basic();
		t_prog();
		t_word();
		t_erase();
		stop_test();
	end
	initial begin
		#700000;
		bad_count++;
		stop_test();
	end
endmodule
